// *** sram_cycle_timer.sv ***
// down-counter that paces the access, write pulse and recovery phases of a memory cycle
// loaded by the controller on the clock of the controller
`timescale 1ns/1ps
module sram_cycle_timer
  import sram_timing_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  done_out
);
  logic [CNT_W-1:0] remaining;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      remaining <= '0;
    end else if (load_in) begin
      remaining <= count_in;
    end else if (remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end
  assign done_out = (remaining == '0) && !load_in;
endmodule : sram_cycle_timer

// *** sram_host_ctrl.sv ***
// host controller that runs read and write cycles on an asynchronous 32K x 8 static memory
// assumes the memory pins are wired straight to this block and one 10 MHz clock
// the speed grade is set by the ns figures in the package; cycle counts follow from them
//
// Summary of operation
// - select or write strobe stays high whenever the address changes
// - write strobe stays high for the whole read cycle
// - address intervals run from last address valid to first address change
// - select held low at least 10 ns before write ends
// - address valid by write start and stable 10 ns before write ends
// - address may change at write end, never before
// - write strobe held low at least 10 ns
// - write data valid 6 ns before write end, held until it
// - each write cycle lasts at least 12 ns
`timescale 1ns/1ps
module sram_host_ctrl
  import sram_timing_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic                   mem_select_n_out,
  output logic                   mem_strobe_n_out,
  output logic                   mem_gate_n_out,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0]      mem_data_out,
  output logic                   mem_data_oe_out
);
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [DATA_W-1:0] data_sync1;
  logic [DATA_W-1:0] data_sync2;
  logic              timer_load;
  logic [CNT_W-1:0]  timer_count;
  logic              timer_done;
  logic [CNT_W-1:0]  cycle_age;
  logic              op_write;

  // one shared timer paces access, write pulse and recovery
  sram_cycle_timer u_timer (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .load_in  (timer_load),
    .count_in (timer_count),
    .done_out (timer_done)
  );

  // read data comes from the pins, so it is synchronised before capture
  always_ff @(posedge mclk_in) begin
    data_sync1 <= mem_data_in;
    data_sync2 <= data_sync1;
  end

  // a request counts only while ready shows, so one held across reset release waits its turn
  wire take_req   = (state == IDLE) && req_ready_out && req_valid_in;
  wire take_write = take_req && req_write_in;

  // cycle age since the take keeps back-to-back cycles apart by at least the cycle time
  wire [CNT_W-1:0] min_cycle = op_write ? CNT_W'(WR_CYCLE_CYC) : CNT_W'(RD_CYCLE_CYC);
  wire             cycle_met = (cycle_age >= min_cycle);

  // age saturates so a long idle spell never wraps back below the minimum
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cycle_age <= '0;
      op_write  <= 1'b0;
    end else if (take_req) begin
      cycle_age <= '0;
      op_write  <= req_write_in;
    end else if (cycle_age != '1) begin
      cycle_age <= cycle_age + 1'b1;
    end
  end

  // access and write pulse end on the cycle the timer shows done; recovery also waits for cycle_met
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_count = '0;
    unique case (state)
      IDLE: begin
        if (take_req) begin
          next_state = req_write_in ? WR_SETUP : RD_ACCESS;
          // writes start with a setup cycle, so only reads load the timer here
          timer_load = !req_write_in;
          // extra cycles cover the two-stage synchroniser on read data
          timer_count = CNT_W'(RD_WAIT_CYC + 2);
        end
      end
      RD_ACCESS: begin
        // select and gate stay low until access time plus synchroniser delay has run out
        if (timer_done) next_state = RD_DONE;
      end
      RD_DONE: begin
        // select and gate rise together; the memory floats its outputs during recovery
        next_state  = RECOVER;
        timer_load  = 1'b1;
        timer_count = CNT_W'(RECOVER_CYC);
      end
      WR_SETUP: begin
        // address and data sit on the pins a full cycle before the strobe falls
        next_state  = WR_PULSE;
        timer_load  = 1'b1;
        timer_count = CNT_W'(WR_PULSE_CYC);
      end
      WR_PULSE: begin
        // strobe stays low for the whole count; address and data do not move here
        if (timer_done) next_state = WR_END;
      end
      WR_END: begin
        // data stays driven one more cycle as hold after the write ends
        next_state  = RECOVER;
        timer_load  = 1'b1;
        timer_count = CNT_W'(RECOVER_CYC);
      end
      RECOVER: begin
        // bus turnaround, and no new cycle before the minimum cycle time has passed
        if (timer_done && cycle_met) next_state = IDLE;
      end
    endcase
  end

  // pin levels per state; select rises with strobe so the write ends on both together
  function automatic logic select_on(input ctrl_state_t s);
    return s inside {RD_ACCESS, RD_DONE, WR_SETUP, WR_PULSE};
  endfunction : select_on

  function automatic logic strobe_on(input ctrl_state_t s);
    return s == WR_PULSE;
  endfunction : strobe_on

  // the gate is only low in read states, so it never overlaps the write strobe
  function automatic logic gate_on(input ctrl_state_t s);
    return s inside {RD_ACCESS, RD_DONE};
  endfunction : gate_on

  // controller drives data only from setup to one cycle after write end, never while gated
  function automatic logic drive_on(input ctrl_state_t s);
    return s inside {WR_SETUP, WR_PULSE, WR_END};
  endfunction : drive_on

  wire next_select_n = !select_on(next_state);
  wire next_strobe_n = !strobe_on(next_state);
  wire next_gate_n   = !gate_on(next_state);
  wire next_oe       = drive_on(next_state);

  // every pin is a flop so the memory sees clean edges with no decode glitches
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state            <= IDLE;
      mem_select_n_out <= 1'b1;
      mem_strobe_n_out <= 1'b1;
      mem_gate_n_out   <= 1'b1;
      mem_data_oe_out  <= 1'b0;
    end else begin
      state            <= next_state;
      mem_select_n_out <= next_select_n;
      mem_strobe_n_out <= next_strobe_n;
      mem_gate_n_out   <= next_gate_n;
      mem_data_oe_out  <= next_oe;
    end
  end

  // address only loads from idle, when select and strobe are both high
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mem_addr_out <= '0;
    end else if (take_req) begin
      mem_addr_out <= req_addr_in;
    end
  end

  // write data only loads on a write, so a read leaves the last driven byte in place
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mem_data_out <= '0;
    end else if (take_write) begin
      mem_data_out <= req_wdata_in;
    end
  end

  // the last read stage samples the second synchroniser flop, never the first
  wire read_done = (state == RD_DONE);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
    end else begin
      req_ready_out <= (next_state == IDLE);
      rsp_valid_out <= read_done;
    end
  end

  // read data holds until the next read completes
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rsp_rdata_out <= '0;
    end else if (read_done) begin
      rsp_rdata_out <= data_sync2;
    end
  end
endmodule : sram_host_ctrl

// *** sram_host_ctrl_chk.sv ***
// assertions on the host controller request port and memory pins
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/1ps
module sram_host_ctrl_chk
  import sram_timing_pkg::*;
(
  input wire logic              mclk_in,
  input wire logic              reset_in,
  input wire logic              req_valid_in,
  input wire logic              req_write_in,
  input wire logic              req_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic              mem_select_n_out,
  input wire logic              mem_strobe_n_out,
  input wire logic              mem_gate_n_out,
  input wire logic              mem_data_oe_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic [DATA_W-1:0] mem_data_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire take = req_valid_in && req_ready_out;
  property p_addr; !$stable(mem_addr_out) |-> mem_strobe_n_out && $past(mem_strobe_n_out); endproperty
  a_addr: assert property (p_addr) else $error("address moved under strobe");
  property p_gate; !mem_gate_n_out |-> mem_strobe_n_out; endproperty
  a_gate: assert property (p_gate) else $error("strobe low in read");
  // the strobe stays low two samples, with select low before and during it
  property p_pulse;
    $fell(mem_strobe_n_out) |-> !$past(mem_select_n_out) && !mem_select_n_out
      ##1 (!mem_strobe_n_out && !mem_select_n_out) ##1 (mem_strobe_n_out && mem_select_n_out);
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad write pulse");
  property p_wsetup; $fell(mem_strobe_n_out) |-> $stable(mem_addr_out) && !mem_select_n_out; endproperty
  a_wsetup: assert property (p_wsetup) else $error("address not set up");
  property p_wdata; $fell(mem_strobe_n_out) |-> mem_data_oe_out && $stable(mem_data_out); endproperty
  a_wdata: assert property (p_wdata) else $error("write data not set up");
  property p_wcyc; take && req_write_in |-> ##1 !req_ready_out [*6] ##1 req_ready_out; endproperty
  a_wcyc: assert property (p_wcyc) else $error("write cycle too short");
  property p_read;
    take && !req_write_in |-> ##1 (!mem_select_n_out && !mem_gate_n_out) [*5] ##1 (rsp_valid_out && mem_select_n_out);
  endproperty
  a_read: assert property (p_read) else $error("read timing wrong");
  property p_hold; !mem_select_n_out && !$past(mem_select_n_out) |-> $stable(mem_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("address moved while selected");
  c_wr: cover property (take && req_write_in);
  c_rd: cover property (rsp_valid_out);
  c_busy: cover property (req_valid_in && !req_ready_out);
endmodule : sram_host_ctrl_chk

// *** sram_mem_model.sv ***
// cycle-level model of the static memory on the controller's pins
// assumes the bench resolves the shared data bus from the controller's output enable alone
`timescale 1ns/1ps
module sram_mem_model
  import sram_timing_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              select_n_in,
  input  wire logic              strobe_n_in,
  input  wire logic              gate_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last = 8'h00;
  wire drive = !select_n_in && !gate_n_in && strobe_n_in;
  // zero delays meet every access and release bound; floating bus shows the inverse
  assign data_out = drive ? mem[addr_in] : ~last;
  // power state follows selection; the sleep delay ends well inside one clock
  wire active_power_state = !select_n_in;
  always @(posedge mclk_in) begin
    if (drive) last <= mem[addr_in];
    if (!select_n_in && !strobe_n_in) mem[addr_in] <= data_in;
  end
endmodule : sram_mem_model

// *** sram_timing_pkg.sv ***
// timing constants and state types for the asynchronous static memory controller
// assumes a single 10 MHz clock; all figures are for the fastest speed grade
package sram_timing_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ADDR_W        = 15;
  localparam int unsigned DATA_W        = 8;
  // read timing (ns)
  localparam int unsigned READ_CYCLE_NS   = 12;
  localparam int unsigned ADDR_ACCESS_NS  = 12;
  localparam int unsigned SEL_ACCESS_NS   = 12;
  localparam int unsigned GATE_ACCESS_NS  = 6;
  localparam int unsigned SEL_RELEASE_NS  = 5;
  localparam int unsigned GATE_RELEASE_NS = 5;
  localparam int unsigned auto_sleep_delay_NS = 15;
  // write timing (ns)
  localparam int unsigned WRITE_CYCLE_NS  = 12;
  localparam int unsigned SEL_TO_END_NS   = 10;
  localparam int unsigned ADDR_TO_END_NS  = 10;
  localparam int unsigned STROBE_WIDTH_NS = 10;
  localparam int unsigned DATA_SETUP_NS   = 6;
  localparam int unsigned STROBE_OFF_NS   = 4;
  // least times round up, never below one cycle
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles
  localparam int unsigned RD_WAIT_CYC = ns_to_cycles(ADDR_ACCESS_NS > GATE_ACCESS_NS ? ADDR_ACCESS_NS : GATE_ACCESS_NS);
  localparam int unsigned WR_PULSE_CYC = ns_to_cycles(STROBE_WIDTH_NS);
  localparam int unsigned RECOVER_CYC = ns_to_cycles(SEL_RELEASE_NS);
  localparam int unsigned RD_CYCLE_CYC = ns_to_cycles(READ_CYCLE_NS);
  localparam int unsigned WR_CYCLE_CYC = ns_to_cycles(WRITE_CYCLE_NS);
  localparam int unsigned CNT_W = 4;
  typedef enum logic [2:0] {IDLE, RD_ACCESS, RD_DONE, WR_SETUP, WR_PULSE, WR_END, RECOVER} ctrl_state_t;
endpackage : sram_timing_pkg

// *** test_sram_host_ctrl.sv ***
// self-checking bench: host controller against the memory model
// assumes the package timing constants and a 10 MHz clock
`timescale 1ns/1ps
module test_sram_host_ctrl;
  import sram_timing_pkg::*;
  logic              mclk_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = 15'h0000, mem_addr_out;
  logic [DATA_W-1:0] req_wdata_in = 8'h00, rsp_rdata_out, mem_data_out, mem_drive;
  logic              req_ready_out, rsp_valid_out, mem_select_n_out, mem_strobe_n_out, mem_gate_n_out, mem_data_oe_out;
  wire  [DATA_W-1:0] mem_data_in = mem_data_oe_out ? mem_data_out : mem_drive;
  int                n_errors = 0, checks = 0;
  always #50 mclk_in = ~mclk_in;
  sram_host_ctrl u_sram_host_ctrl (.mclk_in, .reset_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
    .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .mem_addr_out, .mem_select_n_out, .mem_strobe_n_out,
    .mem_gate_n_out, .mem_data_in, .mem_data_out, .mem_data_oe_out);
  sram_mem_model u_sram_mem_model (.mclk_in, .select_n_in(mem_select_n_out), .strobe_n_in(mem_strobe_n_out),
    .gate_n_in(mem_gate_n_out), .addr_in(mem_addr_out), .data_in(mem_data_in), .data_out(mem_drive));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // polls at falling edges so a registered flag is read settled
  task automatic wait_hi(input bit rsp);
    int i;
    for (i = 0; i < 20 && (rsp ? rsp_valid_out : req_ready_out) !== 1'b1; i++) @(negedge mclk_in);
    if (i == 20) begin
      n_errors++;
      test_done();
    end
  endtask : wait_hi
  task automatic issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge mclk_in);
    {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
    wait_hi(1'b0);
    @(negedge mclk_in);
    req_valid_in = 1'b0;
  endtask : issue
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    issue(1'b0, a, 8'h00);
    wait_hi(1'b1);
    check(rsp_rdata_out, exp);
  endtask : rd
  task automatic t_edges;
    logic [ADDR_W-1:0] a [3] = '{15'h0000, 15'h7fff, 15'h2aaa};
    foreach (a[i]) issue(1'b1, a[i], 8'h5a ^ a[i][7:0]);
    foreach (a[i]) rd(a[i], 8'h5a ^ a[i][7:0]);
    $display("test edges done");
  endtask : t_edges
  task automatic t_rewrite;
    issue(1'b1, 15'h0001, 8'h11);
    issue(1'b1, 15'h0001, 8'h22);
    rd(15'h0001, 8'h22);
    rd(15'h0000, 8'h5a);
    $display("test rewrite done");
  endtask : t_rewrite
  task automatic t_reset;
    issue(1'b0, 15'h7fff, 8'h00);
    reset_in = 1'b1;
    @(negedge mclk_in);
    check({mem_select_n_out, mem_strobe_n_out, mem_gate_n_out, mem_data_oe_out, req_ready_out}, 5'h1c);
    reset_in = 1'b0;
    rd(15'h7fff, 8'ha5);
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (5) @(negedge mclk_in);
    reset_in = 1'b0;
    t_edges();
    t_rewrite();
    t_reset();
    test_done();
  end
endmodule : test_sram_host_ctrl
bind sram_host_ctrl sram_host_ctrl_chk u_sram_host_ctrl_chk (.mclk_in, .reset_in, .req_valid_in, .req_write_in,
  .req_ready_out, .rsp_valid_out, .mem_select_n_out, .mem_strobe_n_out, .mem_gate_n_out, .mem_data_oe_out,
  .mem_addr_out, .mem_data_out);
